// >>> logic/mss_pkg.sv
// Package: opcodes, flag positions and widths for the subtract/swap/skip datapath
package mss_pkg;
  localparam int DATA_W = 8;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SKIP_NZ,
    OP_SUB_ACC,
    OP_SUB_MEM,
    OP_SUB_IMM,
    OP_SWAP
  } mss_op_type;
  // Flag vector bit positions
  localparam int FLG_C   = 0;
  localparam int FLG_AC  = 1;
  localparam int FLG_Z   = 2;
  localparam int FLG_OV  = 3;
  localparam int FLG_SC  = 4;
  localparam int FLG_CZ  = 5;
  localparam int FLG_W   = 6;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int SKIP_DUMMY_CYCLES = 1;
endpackage

// >>> logic/mss_sub_unit.sv
// Subtractor: 8-bit difference with borrow, nibble borrow and signed overflow
`timescale 1ns/1ns
`default_nettype none
module mss_sub_unit #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] minuend,
  input  wire logic [W-1:0] subtrahend,
  output logic      [W-1:0] diff,
  output logic              no_borrow,
  output logic              nib_no_borrow,
  output logic              ovf,
  output logic              signed_lt
);
  logic [W:0] full_w;
  logic [4:0] nib_w;
  // Adding the inverse plus one gives carry-out equal to not-borrow
  assign full_w        = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, 1'b1};
  assign nib_w         = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
  assign diff          = full_w[W-1:0];
  assign no_borrow     = full_w[W];
  assign nib_no_borrow = nib_w[4];
  assign ovf           = (minuend[W-1] ^ subtrahend[W-1]) & (minuend[W-1] ^ full_w[W-1]);
  assign signed_lt     = full_w[W-1] ^ ovf;
endmodule
`default_nettype wire

// >>> logic/mss_datapath.sv
// Datapath for skip-if-nonzero, subtract variants and nibble swap
`timescale 1ns/1ns
`default_nettype none
// Function
// RL1: Skip next instruction when addressed memory byte is nonzero.
// RL2: Skip test writes the read byte back unchanged; flags untouched.
// RL3: Taken skip inserts one dummy cycle, making the instruction two cycles.
// RL4: Zero byte means no skip; the following instruction runs.
// RL5: Subtract memory from accumulator, result to accumulator, memory unchanged.
// RL6: Carry cleared on borrow, set when difference zero or positive.
// RL7: Subtractions update overflow, zero, aux carry, carry, signed and compare-zero flags.
// RL8: Memory-destination subtract writes difference to memory; accumulator unchanged.
// RL9: Immediate subtract takes constant from instruction word, result to accumulator.
// RL10: Swap exchanges memory nibbles in place; flags unchanged.
// RL11: Two's complement; zero, signed overflow, aux carry as low-nibble not-borrow.
module mss_datapath #(
  parameter int W = mss_pkg::DATA_W
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               op_valid,
  input  wire mss_pkg::mss_op_type op_code,
  input  wire logic [W-1:0]       mem_rdata,
  input  wire logic [W-1:0]       imm_data,
  output logic      [W-1:0]       accumulator,
  output logic      [W-1:0]       mem_wdata,
  output logic                    mem_we,
  output logic                    skip_next,
  output logic                    dummy_cycle,
  output logic                    overflow_flag,
  output logic                    zero_flag,
  output logic                    aux_carry_flag,
  output logic                    carry_flag,
  output logic                    signed_compare_flag,
  output logic                    compare_zero_flag
);
  logic [W-1:0] acc_q;
  logic [W-1:0] acc_d;
  logic [5:0]   flags_q;
  logic [5:0]   flags_d;
  logic [W-1:0] wdata_q;
  logic [W-1:0] wdata_d;
  logic         we_q;
  logic         we_d;
  logic         skip_q;
  logic         dummy_q;

  wire logic         is_skip;
  wire logic         is_sub;
  wire logic         is_swap;
  wire logic         is_sub_mem;
  wire logic [W-1:0] sub_rhs;
  wire logic [W-1:0] diff;
  wire logic         no_borrow;
  wire logic         nib_no_borrow;
  wire logic         ovf;
  wire logic         signed_lt;
  wire logic         res_zero;
  wire logic         take_skip;
  wire logic [5:0]   sub_flags;
  wire logic [W-1:0] swapped;

  // A dummy cycle carries no operation, so nothing issued then is executed
  assign is_skip = op_valid & ~dummy_q & (op_code == mss_pkg::OP_SKIP_NZ);
  assign is_sub  = op_valid & ~dummy_q & ((op_code == mss_pkg::OP_SUB_ACC) |
                   (op_code == mss_pkg::OP_SUB_MEM) | (op_code == mss_pkg::OP_SUB_IMM));
  assign is_swap = op_valid & ~dummy_q & (op_code == mss_pkg::OP_SWAP);
  assign is_sub_mem = is_sub & (op_code == mss_pkg::OP_SUB_MEM);
  assign sub_rhs = (op_code == mss_pkg::OP_SUB_IMM) ? imm_data : mem_rdata; // [RL9]

  mss_sub_unit #(
    .W (W)
  ) u_sub (
    .minuend       (acc_q),
    .subtrahend    (sub_rhs),
    .diff          (diff),
    .no_borrow     (no_borrow),
    .nib_no_borrow (nib_no_borrow),
    .ovf           (ovf),
    .signed_lt     (signed_lt)
  );

  assign res_zero  = (diff == mss_pkg::ZERO_BYTE); // [RL11]
  assign take_skip = is_skip & (mem_rdata != mss_pkg::ZERO_BYTE); // [RL1] [RL4]
  assign swapped   = {mem_rdata[3:0], mem_rdata[7:4]}; // [RL10]

  // Compare-zero mirrors the zero flag; signed compare is the signed greater-or-equal of the same subtract
  assign sub_flags[mss_pkg::FLG_C]  = no_borrow; // [RL6]
  assign sub_flags[mss_pkg::FLG_AC] = nib_no_borrow; // [RL11]
  assign sub_flags[mss_pkg::FLG_Z]  = res_zero;
  assign sub_flags[mss_pkg::FLG_OV] = ovf; // [RL11]
  assign sub_flags[mss_pkg::FLG_SC] = ~signed_lt;
  assign sub_flags[mss_pkg::FLG_CZ] = res_zero;

  assign acc_d   = (is_sub & ~is_sub_mem) ? diff : acc_q; // [RL5] [RL9]
  assign flags_d = is_sub ? sub_flags : flags_q; // [RL7] [RL2] [RL10]
  assign we_d    = is_skip | is_swap | is_sub_mem; // [RL8]
  assign wdata_d = is_swap ? swapped :
                   is_skip ? mem_rdata : // [RL2]
                   is_sub_mem ? diff : // [RL8]
                   wdata_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      acc_q   <= mss_pkg::ACC_RST;
      flags_q <= mss_pkg::FLAGS_RST;
      wdata_q <= mss_pkg::ZERO_BYTE;
      we_q    <= 1'b0;
      skip_q  <= 1'b0;
      dummy_q <= 1'b0;
    end
    else
    begin
      acc_q   <= acc_d;
      flags_q <= flags_d;
      wdata_q <= wdata_d;
      we_q    <= we_d;
      skip_q  <= take_skip;
      dummy_q <= take_skip; // [RL3]
    end
  end

  assign accumulator         = acc_q;
  assign mem_wdata           = wdata_q;
  assign mem_we              = we_q;
  assign skip_next           = skip_q;
  assign dummy_cycle         = dummy_q;
  assign overflow_flag       = flags_q[mss_pkg::FLG_OV];
  assign zero_flag           = flags_q[mss_pkg::FLG_Z];
  assign aux_carry_flag      = flags_q[mss_pkg::FLG_AC];
  assign carry_flag          = flags_q[mss_pkg::FLG_C];
  assign signed_compare_flag = flags_q[mss_pkg::FLG_SC];
  assign compare_zero_flag   = flags_q[mss_pkg::FLG_CZ];

  // Helper: previous-cycle operands for multi-cycle checks
  logic [W-1:0] acc_prev;
  logic [W-1:0] rhs_prev;
  mss_pkg::mss_op_type op_prev;
  logic         sub_prev;
  logic         swap_prev;
  logic [W-1:0] rd_prev;
  always_ff @(posedge clk)
  begin
    acc_prev  <= acc_q;
    rhs_prev  <= sub_rhs;
    op_prev   <= op_code;
    sub_prev  <= is_sub & ~sys_rst;
    swap_prev <= is_swap & ~sys_rst;
    rd_prev   <= mem_rdata;
  end
  wire logic [W-1:0] diff_prev;
  assign diff_prev = acc_prev - rhs_prev;

  sequence skip_taken_s;
    is_skip && (mem_rdata != mss_pkg::ZERO_BYTE);
  endsequence
  sequence skip_then_dummy_s;
    dummy_cycle && skip_next ##1 !dummy_cycle;
  endsequence
  sequence op_ignored_s;
    $stable(accumulator) && $stable(flags_q) && !mem_we && !skip_next;
  endsequence

  skip_nonzero_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL1]
    skip_taken_s |=> skip_next) else $error("nonzero byte did not skip");
  skip_zero_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL4]
    is_skip && (mem_rdata == mss_pkg::ZERO_BYTE) |=> !skip_next && !dummy_cycle)
    else $error("zero byte skipped");
  skip_dummy_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL3]
    skip_taken_s |=> skip_then_dummy_s) else $error("skip dummy cycle wrong");
  skip_wb_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL2]
    is_skip |=> mem_we && mem_wdata == $past(mem_rdata) && $stable(flags_q))
    else $error("skip writeback or flags wrong");
  sub_acc_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL5]
    sub_prev && op_prev == mss_pkg::OP_SUB_ACC |-> accumulator == 8'(acc_prev - rhs_prev) && !mem_we)
    else $error("acc subtract wrong");
  sub_carry_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL6]
    sub_prev |-> carry_flag == (acc_prev >= rhs_prev)) else $error("carry polarity wrong");
  sub_flags_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL7]
    sub_prev |-> zero_flag == (8'(acc_prev - rhs_prev) == 8'h00) && compare_zero_flag == zero_flag)
    else $error("zero flags wrong");
  sub_mem_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL8]
    sub_prev && op_prev == mss_pkg::OP_SUB_MEM |-> mem_we && mem_wdata == 8'(acc_prev - rhs_prev)
    && accumulator == acc_prev) else $error("memory subtract wrong");
  sub_imm_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL9]
    is_sub && op_code == mss_pkg::OP_SUB_IMM |=> accumulator == 8'($past(acc_q) - $past(imm_data)))
    else $error("immediate subtract wrong");
  swap_nib_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL10]
    swap_prev |-> mem_we && mem_wdata == {rd_prev[3:0], rd_prev[7:4]} && $stable(flags_q))
    else $error("swap wrong");
  aux_carry_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL11]
    sub_prev |-> aux_carry_flag == (acc_prev[3:0] >= rhs_prev[3:0])) else $error("aux carry wrong");
  // Overflow judged against the true signed difference, not the adder's carries
  sub_ovf_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL11]
    sub_prev |-> overflow_flag == (int'($signed(acc_prev)) - int'($signed(rhs_prev)) != int'($signed(diff_prev))))
    else $error("overflow flag wrong");
  sub_signed_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL7]
    sub_prev |-> signed_compare_flag == ($signed(acc_prev) >= $signed(rhs_prev)))
    else $error("signed compare flag wrong");
  imm_nowrite_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL9]
    is_sub && op_code == mss_pkg::OP_SUB_IMM |=> !mem_we)
    else $error("immediate subtract wrote memory");
  // An op offered in the dummy slot must leave no trace
  dummy_ignore_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL3]
    dummy_cycle |=> op_ignored_s)
    else $error("op in dummy cycle took effect");
  skip_pulse_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL3]
    skip_next |=> !skip_next)
    else $error("skip lasted more than one cycle");
  skip_acc_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL2]
    is_skip |=> $stable(accumulator))
    else $error("skip changed accumulator");
  swap_acc_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL10]
    swap_prev |-> accumulator == acc_prev)
    else $error("swap changed accumulator");
  flags_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL2] [RL10]
    !is_sub |=> $stable(flags_q))
    else $error("flags changed without a subtract");
endmodule
`default_nettype wire

// >>> bench/tb_mcu_subtract_swap_skip_ops.sv
// Testbench for the subtract, swap and skip datapath
`timescale 1ns/1ns
`default_nettype none
module tb_mcu_subtract_swap_skip_ops;
  logic                clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic                op_valid = 1'b0;
  mss_pkg::mss_op_type op_code = mss_pkg::OP_NONE;
  logic [7:0]          mem_rdata = 8'h00;
  logic [7:0]          imm_data = 8'h00;
  logic [7:0]          accumulator;
  logic [7:0]          mem_wdata;
  logic                mem_we;
  logic                skip_next;
  logic                dummy_cycle;
  wire logic [5:0]     flags_seen;
  logic [7:0]          acc_m = 8'h00;
  logic [5:0]          flg_m = 6'h00;
  int                  mismatches = 0;
  int                  n_checks = 0;
  int                  cycles = 0;

  mss_datapath u_dut (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .op_valid            (op_valid),
    .op_code             (op_code),
    .mem_rdata           (mem_rdata),
    .imm_data            (imm_data),
    .accumulator         (accumulator),
    .mem_wdata           (mem_wdata),
    .mem_we              (mem_we),
    .skip_next           (skip_next),
    .dummy_cycle         (dummy_cycle),
    .overflow_flag       (flags_seen[mss_pkg::FLG_OV]),
    .zero_flag           (flags_seen[mss_pkg::FLG_Z]),
    .aux_carry_flag      (flags_seen[mss_pkg::FLG_AC]),
    .carry_flag          (flags_seen[mss_pkg::FLG_C]),
    .signed_compare_flag (flags_seen[mss_pkg::FLG_SC]),
    .compare_zero_flag   (flags_seen[mss_pkg::FLG_CZ])
  );

  initial
  begin
    forever #2 clk = ~clk;
  end

  task automatic final_report;
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Flags that a subtract a - b must leave, in the package's bit order
  function automatic logic [5:0] flags_after(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    flags_after = 6'h00;
    flags_after[mss_pkg::FLG_C]  = (a >= b);
    flags_after[mss_pkg::FLG_AC] = (a[3:0] >= b[3:0]);
    flags_after[mss_pkg::FLG_Z]  = (d == 8'h00);
    flags_after[mss_pkg::FLG_OV] = (a[7] != b[7]) && (d[7] != a[7]);
    flags_after[mss_pkg::FLG_SC] = ($signed(a) >= $signed(b));
    flags_after[mss_pkg::FLG_CZ] = (d == 8'h00);
  endfunction

  // Issues one op and returns just after the edge that takes it
  task automatic run(input mss_pkg::mss_op_type op, input logic [7:0] m, input logic [7:0] i);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= op;
    mem_rdata <= m;
    imm_data <= i;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask

  // Immediate ops see the inverse on the memory input, so a wrong operand mux shows
  task automatic test_sub;
    mss_pkg::mss_op_type ops [5] = '{mss_pkg::OP_SUB_IMM, mss_pkg::OP_SUB_ACC, mss_pkg::OP_SUB_IMM,
                                     mss_pkg::OP_SUB_MEM, mss_pkg::OP_SUB_ACC};
    logic [7:0] b [5] = '{8'h01, 8'hFF, 8'h80, 8'h7F, 8'h10};
    logic [7:0] d;
    logic       imm;
    for (int k = 0; k < 5; k++)
    begin
      imm = (ops[k] == mss_pkg::OP_SUB_IMM);
      run(ops[k], imm ? ~b[k] : b[k], imm ? b[k] : ~b[k]);
      d = acc_m - b[k];
      flg_m = flags_after(acc_m, b[k]);
      if (ops[k] != mss_pkg::OP_SUB_MEM)
        acc_m = d;
      check(accumulator, acc_m);
      check(8'(flags_seen), 8'(flg_m));
      check(8'(mem_we), 8'(ops[k] == mss_pkg::OP_SUB_MEM));
      if (ops[k] == mss_pkg::OP_SUB_MEM)
        check(mem_wdata, d);
    end
  endtask

  // The op offered next runs only for a zero byte; a taken skip must drop it
  task automatic test_skip(input logic [7:0] m);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= mss_pkg::OP_SKIP_NZ;
    mem_rdata <= m;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= mss_pkg::OP_SUB_IMM;
    imm_data <= 8'h01;
    #1;
    check(8'(skip_next), 8'(m != 8'h00));
    check(8'(dummy_cycle), 8'(m != 8'h00));
    check(8'(mem_we), 8'h01);
    check(mem_wdata, m);
    check(8'(flags_seen), 8'(flg_m));
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    if (m == 8'h00)
    begin
      flg_m = flags_after(acc_m, 8'h01);
      acc_m = acc_m - 8'h01;
    end
    check(8'({skip_next, dummy_cycle, mem_we}), 8'h00);
    check(accumulator, acc_m);
    check(8'(flags_seen), 8'(flg_m));
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      mismatches++;
      final_report();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check(accumulator, 8'h00);
    check(8'({flags_seen, mem_we, skip_next}), 8'h00);
    test_sub();
    test_skip(8'h05);
    test_skip(8'h00);
    run(mss_pkg::OP_SWAP, 8'hA5, 8'h00);
    check(mem_wdata, 8'h5A);
    check(accumulator, acc_m);
    check(8'({flags_seen, mem_we}), 8'({flg_m, 1'b1}));
    final_report();
  end
endmodule
`default_nettype wire
